// [rtl/cpt_pkg.sv]
// Constants and types for the processor-to-PCI space translator
//--------------------------------------------------------------
// Notes on behaviour
//--------------------------------------------------------------
// Notes on behaviour
// - Address 33:32 = 10 is sparse memory
// - Sparse memory: bus 29:5 to PCI 26:2
// - Holes on: lowest 16MB gives top zeros
// - Holes on: 16MB-128MB uses extension bits
// - Sparse I/O issues PCI I/O cycles
// - Sparse I/O spans 8MB
// - First 64KB I/O fixed at zero
// - Upper I/O placed by nine-bit extension
// - Address 33:28 = 111010 is sparse I/O
// - Low I/O: top zero, 20:7 to 15:2
// - High I/O: extension top, 25:19 copied
// - Dense region issues PCI memory cycles
// - Two extension bits pick dense quarter
// - Address 33:30 = 1111 is dense
// - Dense read: two phases, all enables
// - Dense read bits 4:3 from size bits
// - Dense write: eight phases, masked null
// - Dense write counts bits 4:2 upward
// - Any dense longword mask combination accepted
// - Holes off: extension picks 128MB chunk
// - Bits 1:0 zero memory, encoded I/O
// - Write size from nonzero mask pair
// - Other masks: null-mask longword write
package cpt_pkg;
  // Region decode values on system bus address bits
  localparam logic [1:0] SPM_DEC = 2'h2;
  localparam logic [5:0] SIO_DEC = 6'h3A;
  localparam logic [3:0] DNS_DEC = 4'hF;
  // PCI bus commands
  localparam logic [3:0] CMD_IO_RD  = 4'h2;
  localparam logic [3:0] CMD_IO_WR  = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  // Active-low byte enables
  localparam logic [3:0] BE_ALL  = 4'h0;
  localparam logic [3:0] BE_NONE = 4'hF;
  // Burst lengths, as last-beat index
  localparam logic [2:0] RD_LAST = 3'h1;
  localparam logic [2:0] WR_LAST = 3'h7;
  // Values after reset
  localparam logic [31:0] ADDR_RST = 32'h0;
  localparam logic [7:0]  MASK_RST = 8'h0;
  // Processor request, captured address cycle
  typedef struct packed {
    logic [31:0] addr;    // System bus address bits
    logic [7:0]  wmask;   // Processor write mask
    logic [7:0]  lwmask;  // System bus longword mask
    logic        sz_hi;   // Size bit at lane 124
    logic        sz_lo;   // Size bit at lane 92
    logic        write;   // High for writes
  } cpt_req_t;
  // One PCI data phase
  typedef struct packed {
    logic [31:0] addr;    // PCI address of this phase
    logic [3:0]  cmd;     // PCI command
    logic [3:0]  be_n;    // Byte enables, low active
    logic        last;    // Final phase of burst
  } cpt_phase_t;
endpackage

// [rtl/cpt_translator.sv]
// Processor-to-PCI space translator: decode, address and burst build
`timescale 1ns/1ps
module cpt_translator (
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  input  wire cpt_pkg::cpt_req_t   req,
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire logic [4:0]          sparse_mem_addr_extension,
  input  wire logic [8:0]          sparse_io_addr_extension,
  input  wire logic [1:0]          dense_mem_addr_extension,
  input  wire logic                pc_holes_en,
  output cpt_pkg::cpt_phase_t      phase,
  output logic                     phase_valid,
  input  wire logic                phase_ready,
  output logic                     return_upper,
  output logic                     decode_miss
);
  import cpt_pkg::*;

  //------------------------------------------------------------
  // State
  //------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,  // Waiting for a request
    ST_SPR  = 4'h2,  // One sparse phase
    ST_DRD  = 4'h4,  // Dense read burst
    ST_DWR  = 4'h8   // Dense write burst
  } cpt_state_t;

  cpt_state_t  state;       // Current state
  cpt_state_t  next_state;  // Next state
  logic [31:0] cur_addr;    // Phase address
  logic [3:0]  cur_cmd;     // Phase command
  logic [3:0]  cur_be;      // Phase enables
  logic [2:0]  beat;        // Phase index
  logic [7:0]  lw_mask;     // Dense write longword valid

  //------------------------------------------------------------
  // Decode, from the address as presented
  //------------------------------------------------------------
  wire [31:0] a = req.addr;  // Short alias
  // Patterns are disjoint: 10, 111010, 1111
  wire hit_spm = a[31:30] == SPM_DEC;
  wire hit_sio = a[31:26] == SIO_DEC;
  wire hit_dns = a[31:28] == DNS_DEC;
  wire accept  = req_valid && req_ready;
  wire adv     = phase_valid && phase_ready;

  // Mask pairs that carry data
  wire [3:0] pair_nz = {|req.wmask[7:6], |req.wmask[5:4],
                        |req.wmask[3:2], |req.wmask[1:0]};
  // Exactly one pair may be set
  wire mask_ok = (pair_nz != 4'h0)
              && ((pair_nz & (pair_nz - 4'h1)) == 4'h0);
  // Pair index gives the write size code
  wire [1:0] wr_size = pair_nz[3] ? 2'h3 :
                       pair_nz[2] ? 2'h2 :
                       pair_nz[1] ? 2'h1 : 2'h0;
  wire bad_wr = req.write && !mask_ok;
  wire [1:0] size = req.write ? wr_size : {req.sz_hi, req.sz_lo};
  wire [1:0] off  = a[4:3];                 // Offset field

  //------------------------------------------------------------
  // Sparse byte enables from offset and size
  //------------------------------------------------------------
  function automatic logic [3:0] spr_be(input logic [1:0] o,
                                        input logic [1:0] s);
    logic [3:0] r;
    r = BE_ALL;
    case (s)
      2'h0: r = ~(4'h1 << o);                    // Byte
      2'h1: r = (o == 2'h0) ? 4'hC :             // Word
                (o == 2'h1) ? 4'h9 : 4'h3;
      2'h2: r = (o == 2'h0) ? 4'h8 : 4'h1;       // Tribyte
      default: r = BE_ALL;                       // Longword
    endcase
    return r;
  endfunction

  // Invalid masks send a longword with nothing enabled
  wire [3:0] spm_be = bad_wr ? BE_NONE : spr_be(off, size);
  // I/O address low bits come from offset; long forms use 00
  wire [1:0] io_lo  = (bad_wr || size == 2'h3) ? 2'h0 : off;

  //------------------------------------------------------------
  // Sparse memory address
  //------------------------------------------------------------
  // Lowest 16MB: PCI bits 26:24 clear, i.e. bus bits 29:27
  wire low16 = a[29:27] == 3'h0;
  wire [4:0] spm_top = (pc_holes_en && low16)
                     ? 5'h0
                     : sparse_mem_addr_extension;
  // Memory cycles keep bits 1:0 at zero
  wire [31:0] spm_addr = {spm_top, a[29:5], 2'h0};

  //------------------------------------------------------------
  // Sparse I/O address
  //------------------------------------------------------------
  // Bits 25:19 zero select the fixed lower 64KB
  wire io_low = a[25:19] == 7'h0;
  // Upper part: 9 + 7 + 14 bits spans 8MB per window
  wire [31:0] sio_addr = io_low
    ? {16'h0, a[18:5], io_lo}
    : {sparse_io_addr_extension, a[25:19],
       a[18:5], io_lo};

  //------------------------------------------------------------
  // Dense addresses
  //------------------------------------------------------------
  // Quarter chosen by extension; reset software loads 11
  wire [31:0] drd_addr = {dense_mem_addr_extension, a[27:3],
                          req.sz_hi, req.sz_lo, 3'h0};
  wire [31:0] dwr_addr = {dense_mem_addr_extension, a[27:3],
                          5'h0};

  //------------------------------------------------------------
  // Command selection
  //------------------------------------------------------------
  wire [3:0] spm_cmd = req.write ? CMD_MEM_WR : CMD_MEM_RD;
  wire [3:0] sio_cmd = req.write ? CMD_IO_WR : CMD_IO_RD;

  //------------------------------------------------------------
  // Next state
  //------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (req_valid) begin
          if (hit_spm || hit_sio) begin
            next_state = ST_SPR;
          end else if (hit_dns && req.write) begin
            next_state = ST_DWR;
          end else if (hit_dns) begin
            next_state = ST_DRD;
          end
        end
      end
      ST_SPR: begin
        if (adv) begin
          next_state = ST_IDLE;
        end
      end
      ST_DRD: begin
        if (adv && beat == RD_LAST) begin
          next_state = ST_IDLE;
        end
      end
      ST_DWR: begin
        if (adv && beat == WR_LAST) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  //------------------------------------------------------------
  // Handshake outputs
  //------------------------------------------------------------
  // Requests are taken only between bursts, never overlapped
  assign req_ready   = state == ST_IDLE;
  assign phase_valid = state != ST_IDLE;
  assign phase.addr  = cur_addr;
  assign phase.cmd   = cur_cmd;
  assign phase.be_n  = cur_be;
  assign phase.last  = (state == ST_SPR)
                    || (state == ST_DRD && beat == RD_LAST)
                    || (state == ST_DWR && beat == WR_LAST);

  //------------------------------------------------------------
  // State register
  //------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  //------------------------------------------------------------
  // Phase registers: loaded on accept, stepped per phase
  //------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_addr <= ADDR_RST;
      cur_cmd  <= CMD_MEM_RD;
      cur_be   <= BE_NONE;
      beat     <= 3'h0;
      lw_mask  <= MASK_RST;
    end else if (accept) begin
      beat    <= 3'h0;
      lw_mask <= req.lwmask;
      if (hit_spm) begin
        cur_addr <= spm_addr;
        cur_cmd  <= spm_cmd;
        cur_be   <= spm_be;
      end else if (hit_sio) begin
        cur_addr <= sio_addr;
        cur_cmd  <= sio_cmd;
        cur_be   <= spm_be;
      end else if (req.write) begin
        cur_addr <= dwr_addr;
        cur_cmd  <= CMD_MEM_WR;
        cur_be   <= req.lwmask[0] ? BE_ALL : BE_NONE;
      end else begin
        cur_addr <= drd_addr;
        cur_cmd  <= CMD_MEM_RD;
        cur_be   <= BE_ALL;
      end
    end else if (adv && !phase.last) begin
      // Write steps 4:2 through 000..111; read takes next longword
      beat          <= beat + 3'h1;
      cur_addr[4:2] <= cur_addr[4:2] + 3'h1;
      if (state == ST_DWR) begin
        cur_be <= lw_mask[beat + 3'h1] ? BE_ALL : BE_NONE;
      end
    end
  end

  //------------------------------------------------------------
  // Read return lane and miss flag
  //------------------------------------------------------------
  // Miss is a one-cycle pulse; no PCI cycle is raised for it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      return_upper <= 1'b0;
      decode_miss  <= 1'b0;
    end else begin
      decode_miss <= accept && !hit_spm && !hit_sio && !hit_dns;
      if (accept && hit_dns && !req.write) begin
        return_upper <= req.sz_hi;
      end
    end
  end

  //------------------------------------------------------------
  // Assertions
  //------------------------------------------------------------
  property p_excl;
    @(posedge core_clk) disable iff (!rst_b)
      (32'(hit_spm) + 32'(hit_sio) + 32'(hit_dns)) <= 1;
  endproperty
  a_excl: assert property (p_excl)
    else $error("region decodes overlap");

  // Every taken request leaves by exactly one route: a burst or a miss
  property p_route;
    @(posedge core_clk) disable iff (!rst_b)
      accept |=> phase_valid != decode_miss;
  endproperty
  a_route: assert property (p_route)
    else $error("request neither issued nor missed");

  property p_spm;
    @(posedge core_clk) disable iff (!rst_b)
      accept && hit_spm |=> phase_valid && cur_addr[1:0] == 2'h0
        && cur_cmd[3:2] == 2'h1;
  endproperty
  a_spm: assert property (p_spm)
    else $error("sparse memory cycle malformed");

  property p_hole;
    @(posedge core_clk) disable iff (!rst_b)
      accept && hit_spm && pc_holes_en && low16
        |=> cur_addr[31:27] == 5'h0;
  endproperty
  a_hole: assert property (p_hole)
    else $error("hole access not at zero");

  property p_sext;
    @(posedge core_clk) disable iff (!rst_b)
      accept && hit_spm && !(pc_holes_en && low16)
        |=> cur_addr[31:27] == $past(sparse_mem_addr_extension);
  endproperty
  a_sext: assert property (p_sext)
    else $error("sparse memory top bits wrong");

  property p_iolo;
    @(posedge core_clk) disable iff (!rst_b)
      accept && hit_sio && io_low |=> cur_addr[31:16] == 16'h0
        && cur_cmd[3:2] == 2'h0;
  endproperty
  a_iolo: assert property (p_iolo)
    else $error("low I/O not at zero");

  property p_iohi;
    @(posedge core_clk) disable iff (!rst_b)
      accept && hit_sio && !io_low
        |=> cur_addr[31:23] == $past(sparse_io_addr_extension);
  endproperty
  a_iohi: assert property (p_iohi)
    else $error("high I/O top bits wrong");

  property p_drd;
    @(posedge core_clk) disable iff (!rst_b)
      accept && hit_dns && !req.write |=> cur_be == BE_ALL
        && cur_addr[2:0] == 3'h0 && !phase.last;
  endproperty
  a_drd: assert property (p_drd)
    else $error("dense read burst malformed");

  property p_dwend;
    @(posedge core_clk) disable iff (!rst_b)
      state == ST_DWR && phase.last |-> cur_addr[4:0] == 5'h1C;
  endproperty
  a_dwend: assert property (p_dwend)
    else $error("dense write did not end at 111");

  property p_bad;
    @(posedge core_clk) disable iff (!rst_b)
      accept && hit_spm && bad_wr |=> cur_be == BE_NONE;
  endproperty
  a_bad: assert property (p_bad)
    else $error("invalid mask not nulled");

  c_dwr: cover property (@(posedge core_clk) state == ST_DWR && adv && phase.last);
  c_drd: cover property (@(posedge core_clk) state == ST_DRD && adv && phase.last);
  c_sio: cover property (@(posedge core_clk) accept && hit_sio && !io_low);
endmodule

// [verif/cpt_pci_target.sv]
// PCI target model: takes phases in order, optionally stalling
`timescale 1ns/1ps
module cpt_pci_target (
  input  wire logic                core_clk,
  input  wire cpt_pkg::cpt_phase_t phase,
  input  wire logic                phase_valid,
  input  wire logic                slow,
  input  wire logic                clr,
  output logic                     phase_ready
);
  import cpt_pkg::*;
  cpt_phase_t got [16];  // Accepted phases, oldest first
  int         cnt = 0;   // Phases taken since the last clear
  initial phase_ready = 1'b0;
  // Ready moves off the sampling edge; slow mode stalls every other cycle
  always @(negedge core_clk) begin
    phase_ready <= slow ? ~phase_ready : 1'b1;
  end
  // Record each handshake; the cap keeps a runaway burst from overrunning
  always @(posedge core_clk) begin
    if (clr) begin
      cnt <= 0;
    end else if (phase_valid && phase_ready && cnt < 16) begin
      got[cnt] <= phase;
      cnt      <= cnt + 1;
    end
  end
endmodule

// [verif/cpt_translator_tb.sv]
// Self-checking bench for the processor-to-PCI space translator
`timescale 1ns/1ps
module cpt_translator_tb;
  import cpt_pkg::*;
  logic        core_clk, rst_b, req_valid, req_ready, pc_holes_en;
  logic        phase_valid, phase_ready, return_upper, decode_miss, slow, clr;
  logic [4:0]  mem_ext;      // Sparse memory extension
  logic [8:0]  io_ext;       // Sparse I/O extension
  logic [1:0]  dns_ext;      // Dense extension
  cpt_req_t    req;          // Request to the block
  cpt_phase_t  phase;        // Phase shown to the PCI side
  logic [31:0] ea [8];       // Expected phase addresses
  logic [3:0]  eb [8];       // Expected byte enables
  logic [3:0]  ec;           // Expected command
  int          miscompares = 0;
  int          compares = 0;
  int          cycles = 0;   // Cycles run, for the hang limit

  cpt_translator i_dut (.core_clk(core_clk), .rst_b(rst_b), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .sparse_mem_addr_extension(mem_ext),
    .sparse_io_addr_extension(io_ext), .dense_mem_addr_extension(dns_ext),
    .pc_holes_en(pc_holes_en), .phase(phase), .phase_valid(phase_valid),
    .phase_ready(phase_ready), .return_upper(return_upper), .decode_miss(decode_miss));
  cpt_pci_target i_pci (.core_clk(core_clk), .phase(phase), .phase_valid(phase_valid),
    .slow(slow), .clr(clr), .phase_ready(phase_ready));

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Verdict and end of run; the hang limit lands here too
  task automatic summarize();
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic cpt_req_t mk(logic [31:0] a, logic [7:0] wm, logic [7:0] lw,
                                  logic hi, logic lo, logic wr);
    return '{a, wm, lw, hi, lo, wr};
  endfunction

  // One request, then compare every phase the target took against ea/eb/ec
  task automatic run(input cpt_req_t r, input int n, input logic miss);
    int i;
    int hits;
    hits = 0;
    @(negedge core_clk);
    clr = 1'b1;
    @(negedge core_clk);
    clr = 1'b0;
    req = r;
    req_valid = 1'b1;
    // Idle ready means the first edge takes it; watch a few cycles for the miss pulse
    for (i = 0; i < 60 && (i < 3 || req_ready !== 1'b1 || i_pci.cnt != n); i++) begin
      @(negedge core_clk);
      req_valid = 1'b0;
      hits += (decode_miss === 1'b1);
    end
    check(32'(i < 60), 32'h1, "completion");
    check(32'(hits), 32'(miss), "miss pulse");
    check(32'(i_pci.cnt), 32'(n), "phase count");
    for (i = 0; i < n; i++) begin
      check(i_pci.got[i].addr, ea[i], "address");
      check(32'(i_pci.got[i].be_n), 32'(eb[i]), "byte enables");
      check(32'(i_pci.got[i].cmd), 32'(ec), "command");
      check(32'(i_pci.got[i].last), 32'(i == n - 1), "last");
    end
  endtask

  // Sparse memory, holes off: chunk from extension, sizes from mask pairs
  task automatic t_sparse_mem();
    logic [31:0] a;
    pc_holes_en = 1'h0;
    mem_ext = 5'h15;
    a = 32'h8ACE1228;
    ec = CMD_MEM_RD;
    ea[0] = {5'h15, a[29:5], 2'h0};
    eb[0] = 4'hD;
    run(mk(a, 8'h00, 8'h00, 1'h0, 1'h0, 1'h0), 1, 1'h0);
    // Tribyte write at offset 01, size from the 5:4 mask pair
    ec = CMD_MEM_WR;
    eb[0] = 4'h1;
    run(mk(a, 8'h10, 8'h04, 1'h0, 1'h0, 1'h1), 1, 1'h0);
    a = 32'h8ACE1220;
    ea[0] = {5'h15, a[29:5], 2'h0};
    eb[0] = BE_ALL;
    run(mk(a, 8'h40, 8'h40, 1'h0, 1'h0, 1'h1), 1, 1'h0);
    eb[0] = BE_NONE;
    run(mk(a, 8'h05, 8'h05, 1'h0, 1'h0, 1'h1), 1, 1'h0);
  endtask

  // Holes on: lowest 16MB forced to zero top bits, above uses extension
  task automatic t_holes();
    pc_holes_en = 1'h1;
    mem_ext = 5'h1F;
    ec = CMD_MEM_RD;
    eb[0] = BE_ALL;
    ea[0] = {5'h00, 25'(32'h80ABCDE0 >> 5), 2'h0};
    run(mk(32'h80ABCDE0, 8'h00, 8'h00, 1'h1, 1'h1, 1'h0), 1, 1'h0);
    ea[0] = {5'h1F, 25'(32'h88ABCDE0 >> 5), 2'h0};
    run(mk(32'h88ABCDE0, 8'h00, 8'h00, 1'h1, 1'h1, 1'h0), 1, 1'h0);
  endtask

  // Sparse I/O: fixed low 64KB, relocatable remainder
  task automatic t_sparse_io();
    logic [31:0] a;
    io_ext = 9'h1A5;
    a = 32'hE8012350;
    ec = CMD_IO_RD;
    eb[0] = 4'hB;
    ea[0] = {16'h0000, a[18:5], 2'h2};
    run(mk(a, 8'h00, 8'h00, 1'h0, 1'h0, 1'h0), 1, 1'h0);
    // Longword read at offset 11: low address bits must stay 00
    a = 32'hE8012378;
    eb[0] = BE_ALL;
    ea[0] = {16'h0000, a[18:5], 2'h0};
    run(mk(a, 8'h00, 8'h00, 1'h1, 1'h1, 1'h0), 1, 1'h0);
    a = 32'hEAD01240;
    ec = CMD_IO_WR;
    eb[0] = 4'hC;
    ea[0] = {9'h1A5, a[25:19], a[18:5], 2'h0};
    run(mk(a, 8'h04, 8'h04, 1'h0, 1'h0, 1'h1), 1, 1'h0);
    // Two mask pairs set: null enables, low bits 00
    eb[0] = BE_NONE;
    run(mk(a, 8'h05, 8'h05, 1'h0, 1'h0, 1'h1), 1, 1'h0);
  endtask

  // Dense reads under stalls: two phases, size bits pick lane and octaword
  task automatic t_dense_read();
    logic [31:0] a;
    logic [1:0]  x;
    slow = 1'h1;
    a = 32'hF13579A0;
    ec = CMD_MEM_RD;
    for (int j = 0; j < 2; j++) begin
      x = (j == 0) ? 2'h3 : 2'h1;
      dns_ext = x;
      ea[0] = {x, a[27:3], j == 0, j == 1, 3'h0};
      ea[1] = ea[0] + 32'h4;
      eb[0] = BE_ALL;
      eb[1] = BE_ALL;
      // Quadword read only, as the processor must issue in dense space
      run(mk(a, 8'h00, 8'h00, j == 0, j == 1, 1'h0), 2, 1'h0);
      check(32'(return_upper), 32'(j == 0), "octaword");
    end
  endtask

  // Dense writes: eight phases, ascending address, null enables on holes
  task automatic t_dense_write();
    logic [31:0] a;
    logic [7:0]  lw;
    a = 32'hF13579A0;
    dns_ext = 2'h3;
    ec = CMD_MEM_WR;
    for (int j = 0; j < 2; j++) begin
      lw = (j == 0) ? 8'hA5 : 8'hFF;
      for (int k = 0; k < 8; k++) begin
        ea[k] = {2'h3, a[27:3], 3'(k), 2'h0};
        eb[k] = lw[k] ? BE_ALL : BE_NONE;
      end
      // Whole-line write made of longwords, the legal dense write form
      run(mk(a, 8'hFF, lw, 1'h0, 1'h0, 1'h1), 8, 1'h0);
    end
    slow = 1'h0;
  endtask

  // Addresses outside every region give no phase and a miss pulse
  task automatic t_miss();
    run(mk(32'h40000000, 8'h00, 8'h00, 1'h0, 1'h0, 1'h0), 0, 1'h1);
    run(mk(32'hC0000000, 8'h00, 8'h00, 1'h0, 1'h0, 1'h0), 0, 1'h1);
  endtask

  // Hang limit, well above the roughly 120 cycles the scenarios need
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req = '0;
    pc_holes_en = 1'b0;
    mem_ext = 5'h00;
    io_ext = 9'h000;
    dns_ext = 2'h3;
    slow = 1'b0;
    clr = 1'b0;
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    t_sparse_mem();
    t_holes();
    t_sparse_io();
    t_dense_read();
    t_dense_write();
    t_miss();
    summarize();
  end
endmodule
